// file: common/tcow_pkg.sv
// constants, field layout and timing for the timer output waveform block
// assumes a 25 MHz system clock and a 32-bit APB register port
//
// How it works
// RL1 - frequency mode: equal high and low halves
// RL2 - new frequency value waits for cycle end
// RL3 - disabled output starts new value at once
// RL4 - zero value disables output immediately
// RL5 - disabled output low, high when inverted
// RL6 - resolution doubles per clock-select step
// RL7 - one-shot pulse lasts programmed timer clocks
// RL8 - one-shot rewrite while active reloads length
// RL9 - one-shot length may deviate one timer clock
// RL10 - pulse count emits N square pulses
// RL11 - pulse rate picked by clock select
// RL12 - pulse-count request outstanding until all done
// RL13 - pulse count idles low, pulses high
// RL14 - short pwm duty in 1/256 steps
// RL15 - long pwm duty in 1/65536 steps
// RL16 - new pwm duty applies at period end
// RL17 - triac gate fires delay after sync edge
// RL18 - triac gate timed by fixed 25.6us clock
// RL19 - triac level mode holds until next edge
// RL20 - new triac delay applies at next edge
// RL21 - triac update waits 10 ms for edge
// RL22 - sync edge and gate polarity configurable
// RL23 - 16-bit programmed value, clock-select scaled
// RL24 - train end: output idle, completion flagged
package tcow_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_VALUE = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;

  // ctrl fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_CSEL_LSB = 4;
  localparam int CTRL_INV_BIT = 8;
  localparam int CTRL_EDGE_LSB = 9;
  localparam int CTRL_LVL_BIT = 11;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0200;

  // status fields
  localparam int ST_OUT_BIT = 0;
  localparam int ST_BUSY_BIT = 1;
  localparam int ST_DONE_BIT = 2;
  localparam int ST_TMO_BIT = 3;
  localparam int ST_WAIT_BIT = 4;
  localparam int ST_PEND_BIT = 5;

  // output modes
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_FREQ = 3'h1;
  localparam logic [2:0] MODE_ONESHOT = 3'h2;
  localparam logic [2:0] MODE_PCOUNT = 3'h3;
  localparam logic [2:0] MODE_PWM_S = 3'h4;
  localparam logic [2:0] MODE_PWM_L = 3'h5;
  localparam logic [2:0] MODE_TRIAC = 3'h6;

  // engine states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_WAIT = 2'b10
  } tcow_state_t;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_FREQ_KHZ = 25000;
  localparam logic [7:0] TICK_BASE_DIV = 8'h02;
  localparam logic [15:0] PWM_S_LAST = 16'h00ff;
  localparam logic [15:0] PWM_L_LAST = 16'hffff;
  localparam logic [15:0] PC_LAST = 16'h00ff;
  localparam logic [15:0] PC_HALF = 16'h0080;
  localparam int GATE_CLK_NS = 25600;
  localparam int GATE_CLK_CYC = GATE_CLK_NS * CLK_FREQ_KHZ / 1000000;
  localparam int GATE_CLK_W = 10;
  localparam int TRIAC_TMO_US = 10000;
  localparam int TRIAC_TMO_CYC = TRIAC_TMO_US * (CLK_FREQ_KHZ / 1000);

endpackage : tcow_pkg

// file: hw/tcow_top.sv
// timer output waveform generator: frequency, one-shot, pulse count,
// short and long pwm, triac gate delay
// assumes APB master on REF_CLK_I and SYNC_I synchronous to the clock
`timescale 1ns/1ns
`default_nettype none

module tcow_top
  import tcow_pkg::*;
#(
  parameter int TMO_CYC = TRIAC_TMO_CYC
)
(
  input wire logic REF_CLK_I,
  input wire logic RESET_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic SYNC_I,
  output logic WAVE_O,
  output logic BUSY_O,
  output logic DONE_O
);

  localparam int TMO_W = $clog2(TMO_CYC + 1);
  localparam logic [TMO_W-1:0] TMO_LAST = TMO_W'(TMO_CYC - 1);
  localparam logic [GATE_CLK_W-1:0] GATE_LAST = GATE_CLK_W'(GATE_CLK_CYC - 1);

  typedef struct packed {
    logic [2:0] mode;
    logic [2:0] csel;
    logic inv;
    logic [1:0] edg;
    logic lvl;
    tcow_state_t st;
    logic [15:0] value;
    logic [15:0] pend;
    logic pend_v;
    logic tvld;
    logic [15:0] cnt;
    logic [7:0] pre;
    logic phase;
    logic [15:0] rem;
    logic done;
    logic tmo;
    logic sync_d;
    logic [GATE_CLK_W-1:0] gclk;
    logic dly_run;
    logic arm;
    logic gate;
    logic [TMO_W-1:0] tmo_cnt;
    logic out;
    logic [31:0] rdata;
  } tcow_regs_t;

  tcow_regs_t q;
  tcow_regs_t n;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------

  // register index for a byte address, 2'h3 when unmapped
  function automatic logic [1:0] reg_index(input logic [7:0] a);
    case (a)
      OFS_CTRL: reg_index = 2'h0;
      OFS_VALUE: reg_index = 2'h1;
      OFS_STATUS: reg_index = 2'h2;
      default: reg_index = 2'h3;
    endcase
  endfunction

  // timer clock divides the system clock by 2 << csel
  function automatic logic [7:0] tick_last(input logic [2:0] cs);
    tick_last = (TICK_BASE_DIV << cs) - 8'h01;
  endfunction

  logic tick;
  logic gtick;
  logic sedge;
  logic wr;
  logic wr_ctrl;
  logic wr_val;
  logic wr_stat;
  logic set_done;
  logic set_tmo;
  logic active;
  logic [15:0] wv;
  logic [15:0] cnt_inc;
  logic [15:0] pwm_last;
  logic pwm_mode;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    n = q;
    set_done = 1'b0;
    set_tmo = 1'b0;
    active = 1'b0;
    wv = PWDATA_I[15:0];
    cnt_inc = q.cnt + 16'h0001;
    pwm_mode = (q.mode == MODE_PWM_S) || (q.mode == MODE_PWM_L);
    pwm_last = (q.mode == MODE_PWM_S) ? PWM_S_LAST : PWM_L_LAST; // [RL14] [RL15]
    if (q.mode == MODE_PWM_S)
    begin
      wv = {8'h00, PWDATA_I[7:0]};
    end
    tick = (q.pre == tick_last(q.csel)); // [RL6] [RL11] [RL23]
    gtick = (q.gclk == GATE_LAST); // [RL18]
    sedge = (q.edg[0] && SYNC_I && !q.sync_d) ||
      (q.edg[1] && !SYNC_I && q.sync_d); // [RL22]
    wr = PSEL_I && PENABLE_I && PWRITE_I;
    wr_ctrl = wr && (reg_index(PADDR_I) == 2'h0);
    wr_val = wr && (reg_index(PADDR_I) == 2'h1);
    wr_stat = wr && (reg_index(PADDR_I) == 2'h2);

    // prescaler, zeroed when a value write starts an engine, and free-running fixed gate clock
    n.sync_d = SYNC_I;
    n.pre = tick ? 8'h00 : q.pre + 8'h01;
    n.gclk = gtick ? '0 : q.gclk + GATE_CLK_W'(1);

    // waveform engines
    case (q.mode)
      MODE_FREQ:
      begin
        if (q.st == ST_RUN && tick)
        begin
          if (cnt_inc >= q.value)
          begin
            n.cnt = 16'h0000;
            n.phase = !q.phase; // [RL1]
            if (!q.phase && q.pend_v)
            begin
              n.value = q.pend; // [RL2]
              n.pend_v = 1'b0;
            end
          end
          else
          begin
            n.cnt = cnt_inc;
          end
        end
      end
      MODE_PWM_S, MODE_PWM_L:
      begin
        if (q.st == ST_RUN && tick)
        begin
          if (q.cnt == pwm_last)
          begin
            n.cnt = 16'h0000;
            if (q.pend_v)
            begin
              n.value = q.pend; // [RL16]
              n.pend_v = 1'b0;
            end
          end
          else
          begin
            n.cnt = cnt_inc;
          end
        end
      end
      MODE_ONESHOT:
      begin
        if (q.st == ST_RUN && tick)
        begin
          if (q.cnt == 16'h0001)
          begin
            n.st = ST_IDLE; // [RL7] [RL9]
            n.cnt = 16'h0000;
          end
          else
          begin
            n.cnt = q.cnt - 16'h0001;
          end
        end
      end
      MODE_PCOUNT:
      begin
        if (q.st == ST_RUN && tick)
        begin
          if (q.cnt == PC_LAST)
          begin
            n.cnt = 16'h0000;
            if (q.rem == 16'h0001)
            begin
              n.st = ST_IDLE; // [RL24]
              set_done = 1'b1;
            end
            else
            begin
              n.rem = q.rem - 16'h0001; // [RL10]
            end
          end
          else
          begin
            n.cnt = cnt_inc;
          end
        end
      end
      MODE_TRIAC:
      begin
        // delay then arm; gate follows on the fixed gate clock
        if (q.dly_run && tick)
        begin
          if (q.cnt == q.value)
          begin
            n.dly_run = 1'b0;
            n.arm = 1'b1;
          end
          else
          begin
            n.cnt = cnt_inc;
          end
        end
        if (gtick)
        begin
          if (q.arm)
          begin
            n.gate = 1'b1; // [RL17] [RL18]
            n.arm = 1'b0;
          end
          else if (q.gate && !q.lvl)
          begin
            n.gate = 1'b0;
          end
        end
        if (q.st == ST_WAIT)
        begin
          n.tmo_cnt = q.tmo_cnt + TMO_W'(1);
          if (!sedge && q.tmo_cnt == TMO_LAST)
          begin
            n.st = q.tvld ? ST_RUN : ST_IDLE; // [RL21]
            n.pend_v = 1'b0;
            set_tmo = 1'b1;
          end
        end
        if (sedge && q.st != ST_IDLE)
        begin
          if (q.pend_v)
          begin
            n.value = q.pend; // [RL20]
            n.pend_v = 1'b0;
            n.tvld = 1'b1;
          end
          n.st = ST_RUN;
          n.dly_run = 1'b1;
          n.cnt = 16'h0000;
          n.arm = 1'b0;
          n.gate = 1'b0; // [RL19]
        end
      end
      default:
      begin
        n.st = ST_IDLE;
      end
    endcase

    // value writes override the engine for this cycle
    if (wr_val)
    begin
      case (q.mode)
        MODE_FREQ, MODE_PWM_S, MODE_PWM_L:
        begin
          if (wv == 16'h0000)
          begin
            n.st = ST_IDLE; // [RL4]
            n.pend_v = 1'b0;
          end
          else if (q.st == ST_IDLE)
          begin
            n.st = ST_RUN; // [RL3]
            n.value = wv;
            n.pend_v = 1'b0;
            n.cnt = 16'h0000;
            n.pre = 8'h00;
            n.phase = 1'b1;
          end
          else
          begin
            n.pend = wv; // [RL2] [RL16]
            n.pend_v = 1'b1;
          end
        end
        MODE_ONESHOT:
        begin
          n.st = (wv == 16'h0000) ? ST_IDLE : ST_RUN;
          n.cnt = wv; // [RL8]
          if (q.st == ST_IDLE)
          begin
            n.pre = 8'h00;
          end
        end
        MODE_PCOUNT:
        begin
          // a new train is refused while one is outstanding
          if (q.st == ST_IDLE)
          begin
            if (wv == 16'h0000)
            begin
              set_done = 1'b1;
            end
            else
            begin
              n.st = ST_RUN; // [RL12]
              n.rem = wv;
              n.cnt = 16'h0000;
              n.pre = 8'h00;
            end
          end
        end
        MODE_TRIAC:
        begin
          n.pend = wv;
          n.pend_v = 1'b1;
          n.st = ST_WAIT;
          n.tmo_cnt = '0;
        end
        default:
        begin
          n.value = q.value;
        end
      endcase
    end

    // control write stops every engine
    if (wr_ctrl)
    begin
      n.mode = PWDATA_I[CTRL_MODE_LSB +: 3];
      n.csel = PWDATA_I[CTRL_CSEL_LSB +: 3];
      n.inv = PWDATA_I[CTRL_INV_BIT];
      n.edg = PWDATA_I[CTRL_EDGE_LSB +: 2];
      n.lvl = PWDATA_I[CTRL_LVL_BIT];
      n.st = ST_IDLE;
      n.pend_v = 1'b0;
      n.tvld = 1'b0;
      n.dly_run = 1'b0;
      n.arm = 1'b0;
      n.gate = 1'b0;
    end

    // sticky flags, set wins over write-one-to-clear
    n.done = (q.done && !(wr_stat && PWDATA_I[ST_DONE_BIT])) || set_done;
    n.tmo = (q.tmo && !(wr_stat && PWDATA_I[ST_TMO_BIT])) || set_tmo;

    // output level from the next state
    case (n.mode)
      MODE_FREQ: active = (n.st == ST_RUN) && n.phase;
      MODE_ONESHOT: active = (n.st == ST_RUN);
      MODE_PCOUNT: active = (n.st == ST_RUN) && (n.cnt < PC_HALF); // [RL13]
      MODE_PWM_S, MODE_PWM_L: active = (n.st == ST_RUN) && (n.cnt < n.value);
      MODE_TRIAC: active = n.gate;
      default: active = 1'b0;
    endcase
    n.out = active ^ n.inv; // [RL5] [RL22]

    // read data captured in the setup phase
    if (PSEL_I && !PENABLE_I)
    begin
      case (reg_index(PADDR_I))
        2'h0: n.rdata = {20'h00000, q.lvl, q.edg, q.inv, 1'b0, q.csel,
          1'b0, q.mode};
        2'h1: n.rdata = {16'h0000, q.value};
        2'h2: n.rdata = {26'h0000000, q.pend_v, q.st == ST_WAIT, q.tmo,
          q.done, (q.mode == MODE_PCOUNT) && (q.st == ST_RUN), q.out};
        default: n.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      q <= '0;
      q.edg <= CTRL_RESET[CTRL_EDGE_LSB +: 2];
      q.st <= ST_IDLE;
    end
    else
    begin
      q <= n;
    end
  end

  // bus answers in the first access cycle
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = PSEL_I && PENABLE_I && (reg_index(PADDR_I) == 2'h3);
  assign PRDATA_O = q.rdata;
  assign WAVE_O = q.out;
  assign BUSY_O = (q.mode == MODE_PCOUNT) && (q.st == ST_RUN);
  assign DONE_O = q.done;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (RESET_I);

  sequence wr_zero_s;
    wr_val && wv == 16'h0000 && !wr_ctrl;
  endsequence

  sequence pc_last_s;
    q.mode == MODE_PCOUNT && q.st == ST_RUN && tick && q.cnt == PC_LAST &&
      q.rem == 16'h0001 && !wr_ctrl;
  endsequence

  idle_level_a: assert property (q.st == ST_IDLE && q.mode != MODE_TRIAC
    |-> WAVE_O == q.inv) // [RL5]
    else $error("idle output not at inactive level");

  zero_off_a: assert property ((q.mode == MODE_FREQ || pwm_mode) ##0
    wr_zero_s |=> q.st == ST_IDLE && WAVE_O == q.inv) // [RL4]
    else $error("zero value did not disable output");

  start_now_a: assert property (q.mode == MODE_FREQ && q.st == ST_IDLE &&
    wr_val && wv != 16'h0000 && !wr_ctrl
    |=> q.st == ST_RUN && WAVE_O == !q.inv) // [RL3]
    else $error("disabled output did not start at once");

  pend_hold_a: assert property (q.mode == MODE_FREQ && q.st == ST_RUN &&
    wr_val && wv != 16'h0000 && !wr_ctrl
    |=> q.value == $past(q.value) && q.pend_v) // [RL2]
    else $error("frequency value applied mid cycle");

  oneshot_load_a: assert property (q.mode == MODE_ONESHOT && wr_val &&
    wv != 16'h0000 && !wr_ctrl
    |=> q.cnt == $past(wv) && WAVE_O == !q.inv) // [RL8]
    else $error("one-shot not reloaded");

  pwm_duty_a: assert property (pwm_mode && q.st == ST_RUN
    |-> WAVE_O == ((q.cnt < q.value) ^ q.inv)) // [RL14]
    else $error("pwm level disagrees with duty");

  pc_done_a: assert property (pc_last_s
    |=> q.done && q.st == ST_IDLE && !BUSY_O ##1 DONE_O) // [RL24]
    else $error("pulse train end not flagged");

  gate_clock_a: assert property (q.mode == MODE_TRIAC && $rose(q.gate)
    |-> $past(gtick)) // [RL18]
    else $error("triac gate not on gate clock");

  triac_apply_a: assert property (q.mode == MODE_TRIAC &&
    q.st == ST_WAIT && sedge && q.pend_v && !wr_val && !wr_ctrl
    |=> q.value == $past(q.pend) && q.dly_run && !q.pend_v) // [RL20]
    else $error("triac delay not taken at sync edge");

  triac_tmo_a: assert property (q.mode == MODE_TRIAC &&
    q.st == ST_WAIT && !sedge && q.tmo_cnt == TMO_LAST && !wr_val &&
    !wr_ctrl |=> q.tmo && q.st != ST_WAIT) // [RL21]
    else $error("triac wait did not time out");

endmodule // tcow_top

`default_nettype wire

// file: dv/tcow_load_model.sv
// far-side model: zero-crossing source that feeds the triac sync input
// assumes sync is launched just after the rising edge of the system clock
`timescale 1ns/1ns
`default_nettype none

module tcow_load_model #(
  parameter int HALF = 1500
)
(
  input wire logic clk_i,
  input wire logic en_i,
  output logic sync_o
);
  int cnt;

  // square zero-crossing wave, parked low while the line is off
  always @(posedge clk_i)
  begin
    if (!en_i)
    begin
      cnt <= 0;
      sync_o <= 1'b0;
    end
    else if (cnt == HALF - 1)
    begin
      cnt <= 0;
      sync_o <= !sync_o;
    end
    else
      cnt <= cnt + 1;
  end
endmodule // tcow_load_model

`default_nettype wire

// file: dv/timer_output_waveform_modes_test.sv
// self-checking bench for the timer output waveform block
// assumes the zero-wait APB slave and register map of tcow_pkg
`timescale 1ns/1ns
`default_nettype none

module timer_output_waveform_modes_test;
  import tcow_pkg::*;
  typedef struct {logic [32:0] v; logic [32:0] m; int tol;} tcow_note_t;
  localparam int TMO = 5000;
  localparam int LIMIT = 40000;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, sync, wave, busy, done;
  logic sync_en = 1'b0;
  logic [31:0] lfsr = 32'h5aa7;
  logic [32:0] meas;
  tcow_note_t q[$];
  int miscompares = 0;
  int checks = 0;
  int cyc = 0;
  event got;

  always #20 clk = ~clk;

  tcow_top #(.TMO_CYC(TMO)) tcow_top_inst (
    .REF_CLK_I(clk), .RESET_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .SYNC_I(sync), .WAVE_O(wave), .BUSY_O(busy), .DONE_O(done));

  tcow_load_model #(.HALF(1500)) tcow_load_model_inst (
    .clk_i(clk), .en_i(sync_en), .sync_o(sync));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr_step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [31:0] ctl(input logic [2:0] m, input int c);
    return 32'(m) | (32'(c) << CTRL_CSEL_LSB);
  endfunction

  task automatic note(input logic [32:0] v, input int tol = 0);
    q.push_back('{v, {33{1'b1}}, tol});
  endtask

  task automatic post(input logic [32:0] x);
    meas = x;
    -> got;
    #1;
  endtask

  task automatic bad(input logic [32:0] g, input logic [32:0] e);
    miscompares++;
    $display("unexpected at %0t: got %h exp %h", $time, g, e);
  endtask

  // one APB transfer; holds the request until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    // pready high ends this wait; the hang guard ends it if pready never rises
    do
      @(posedge clk);
    while (pready !== 1'b1);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] e,
                    input logic [32:0] m);
    q.push_back('{e, m, 0});
    apb(1'b0, a, 32'h0);
  endtask

  task automatic wait_lvl(input logic l);
    int k;
    k = 0;
    while (wave !== l && k < 20000)
    begin
      @(negedge clk);
      k++;
    end
  endtask

  task automatic run_len(input logic l, output int n);
    n = 0;
    while (wave === l && n < 20000)
    begin
      @(negedge clk);
      n++;
    end
  endtask

  // ----------------------------------------------------------------
  // result watcher: oldest note against each result
  // ----------------------------------------------------------------
  task automatic cmp_rd(input logic [32:0] g);
    tcow_note_t e;
    checks++;
    if (q.size() == 0)
      bad(g, 33'h0);
    else
    begin
      e = q.pop_front();
      if ((g & e.m) !== (e.v & e.m))
        bad(g, e.v);
    end
  endtask

  task automatic cmp_len(input logic [32:0] g);
    tcow_note_t e;
    logic ok;
    checks++;
    if (q.size() == 0)
      bad(g, 33'h0);
    else
    begin
      e = q.pop_front();
      ok = (g + 33'(e.tol) >= e.v) && (g <= e.v + 33'(e.tol));
      if (ok !== 1'b1)
        bad(g, e.v);
    end
  endtask

  always @(posedge clk)
  begin
    if (psel && pen && !pwr && pready === 1'b1)
      cmp_rd({pslverr, prdata});
  end

  always @(got)
    cmp_len(meas);

  task automatic end_sim();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      miscompares++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    int n, k, p, v, h;
    logic prv;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(OFS_CTRL, {1'b0, CTRL_RESET}, {33{1'b1}});
    rd(OFS_STATUS, 33'h0, {33{1'b1}});
    rd(8'h0c, {1'b1, 32'h0}, {33{1'b1}});
    note(33'h0); post(33'(wave));
    // square wave over several clock selects
    for (int c = 0; c < 3; c++)
    begin
      lfsr = lfsr_step(lfsr);
      v = 2 + int'(lfsr[2:0]);
      h = v * (2 << c);
      wr(OFS_CTRL, ctl(MODE_FREQ, c));
      wr(OFS_VALUE, 32'(v));
      repeat (2) @(negedge clk);
      note(33'h1); post(33'(wave));
      wait_lvl(1'b0);
      wait_lvl(1'b1);
      note(33'(h)); run_len(1'b1, n); post(33'(n));
      note(33'(h)); run_len(1'b0, n); post(33'(n));
    end
    // new value mid-cycle waits for the cycle end
    wait_lvl(1'b1);
    wr(OFS_VALUE, 32'(v + 3));
    wait_lvl(1'b0);
    note(33'(h)); run_len(1'b0, n); post(33'(n));
    note(33'((v + 3) * 8)); run_len(1'b1, n); post(33'(n));
    wait_lvl(1'b1);
    wr(OFS_VALUE, 32'h0);
    repeat (2) @(negedge clk);
    note(33'h0); post(33'(wave));
    wr(OFS_CTRL, ctl(MODE_FREQ, 0) | (32'h1 << CTRL_INV_BIT));
    repeat (2) @(negedge clk);
    note(33'h1); post(33'(wave));
    // one-shot and retrigger
    wr(OFS_CTRL, ctl(MODE_ONESHOT, 0));
    lfsr = lfsr_step(lfsr);
    v = 10 + int'(lfsr[3:0]);
    wr(OFS_VALUE, 32'(v));
    wait_lvl(1'b1);
    note(33'(2 * v), 2); run_len(1'b1, n); post(33'(n));
    wr(OFS_VALUE, 32'd40);
    repeat (10) @(negedge clk);
    wr(OFS_VALUE, 32'd40);
    note(33'd80, 3); run_len(1'b1, n); post(33'(n));
    // pulse train, rewrite while busy is refused
    wr(OFS_CTRL, ctl(MODE_PCOUNT, 1));
    wr(OFS_VALUE, 32'd3);
    wr(OFS_VALUE, 32'd9);
    @(negedge clk);
    note(33'h1); post(33'(busy));
    k = 0;
    p = 0;
    prv = 1'b0;
    while (busy === 1'b1 && k < 4000)
    begin
      @(negedge clk);
      if (wave === 1'b1 && prv === 1'b0)
        p++;
      prv = wave;
      k++;
    end
    note(33'd3); post(33'(p));
    note(33'd3064, 10); post(33'(k));
    note(33'h0); post(33'(wave));
    note(33'h1); post(33'(done));
    rd(OFS_STATUS, 33'h4, 33'h7);
    wr(OFS_STATUS, 32'h4);
    rd(OFS_STATUS, 33'h0, 33'h4);
    wr(OFS_VALUE, 32'h0);
    rd(OFS_STATUS, 33'h4, 33'h6);
    wr(OFS_STATUS, 32'h4);
    // short pwm: lowest, random and highest duty
    wr(OFS_CTRL, ctl(MODE_PWM_S, 0));
    lfsr = lfsr_step(lfsr);
    for (int i = 0; i < 3; i++)
    begin
      v = (i == 0) ? 1 : (i == 1) ? 2 + int'(lfsr[6:0]) : 255;
      wr(OFS_VALUE, 32'(v));
      wait_lvl(1'b0);
      wait_lvl(1'b1);
      note(33'(2 * v)); run_len(1'b1, n); post(33'(n));
      note(33'(512 - 2 * v)); run_len(1'b0, n); post(33'(n));
    end
    wait_lvl(1'b1);
    wr(OFS_VALUE, 32'h0);
    repeat (2) @(negedge clk);
    note(33'h0); post(33'(wave));
    wr(OFS_CTRL, ctl(MODE_PWM_L, 0));
    wr(OFS_VALUE, 32'h1);
    wait_lvl(1'b1);
    note(33'h2, 1); run_len(1'b1, n); post(33'(n));
    // triac: timeout with a dead line, then gating
    wr(OFS_CTRL, ctl(MODE_TRIAC, 0) | (32'h1 << CTRL_EDGE_LSB));
    wr(OFS_VALUE, 32'd4);
    repeat (TMO + 20) @(negedge clk);
    rd(OFS_STATUS, 33'h8, 33'h8);
    @(posedge clk);
    sync_en <= 1'b1;
    wr(OFS_VALUE, 32'd4);
    wait_lvl(1'b1);
    note(33'd640, 1); run_len(1'b1, n); post(33'(n));
    rd(OFS_VALUE, 33'h4, {33{1'b1}});
    @(posedge sync);
    k = 0;
    while (wave !== 1'b1 && k < 1000)
    begin
      @(negedge clk);
      k++;
    end
    note(33'd330, 322); post(33'(k));
    // level gate on both edges drops at the next crossing
    wr(OFS_CTRL, ctl(MODE_TRIAC, 0) | (32'h3 << CTRL_EDGE_LSB)
                 | (32'h1 << CTRL_LVL_BIT));
    wr(OFS_VALUE, 32'd4);
    wait_lvl(1'b1);
    prv = sync;
    k = 0;
    while (sync === prv && k < 4000)
    begin
      @(negedge clk);
      k++;
    end
    note(33'h1); post(33'(wave));
    repeat (4) @(negedge clk);
    note(33'h0); post(33'(wave));
    // inverted gate armed on the falling edge only
    wr(OFS_CTRL, ctl(MODE_TRIAC, 0) | (32'h2 << CTRL_EDGE_LSB)
                 | (32'h1 << CTRL_INV_BIT));
    wr(OFS_VALUE, 32'd4);
    rd(OFS_STATUS, 33'h31, 33'h31);
    @(negedge sync);
    k = 0;
    while (wave !== 1'b0 && k < 1000)
    begin
      @(negedge clk);
      k++;
    end
    note(33'd330, 322); post(33'(k));
    end_sim();
  end
endmodule // timer_output_waveform_modes_test

`default_nettype wire
